// ===== inc/bus_ctrl_pkg.sv
// package: constants and types for the status-decode bus controller
// What this block does
// - sample and update only on falling clock edges
// - active-low status low starts a bus cycle
// - decode space and status into cycle type
// - low space_select means I/O, high memory
// - timing strap selects system-bus or fast timing
// - strap chooses grant-enable or command-enable meaning
// - latch select at status end; gates whole cycle
// - delay high holds command off, resample next
// - ready low before command still ends cycle
// - separate memory, I/O commands, direction, enable
// - idle, status, command states; status and command two clocks each
// - ready high at command end adds wait
// - direction high for writes and idle
// - grant low enables commands, high floats them
package bus_ctrl_pkg;
   // ****************************************************************
   // cycle types
   // ****************************************************************
   typedef enum logic [2:0] {
      CYC_IRQ_ACK = 3'h0,
      CYC_IO_RD = 3'h1,
      CYC_IO_WR = 3'h2,
      CYC_IDLE0 = 3'h3,
      CYC_HALT = 3'h4,
      CYC_MEM_RD = 3'h5,
      CYC_MEM_WR = 3'h6,
      CYC_IDLE1 = 3'h7
   } cycle_t;

   // ****************************************************************
   // bus states, gray along idle-status-command
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_STATUS = 2'h1,
      ST_COMMAND = 2'h3
   } bus_state_t;

   typedef struct packed {
      logic irq_ack;
      logic io_read;
      logic io_write;
      logic mem_read;
      logic mem_write;
   } commands_t;

   localparam logic [4:0] COMMANDS_RESET = 5'h00;
   localparam logic [0:0] PHASE_LAST = 1'h1;
endpackage

// ===== hw/edge_sync.sv
// module: two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] first_r;
   logic [WIDTH-1:0] first_nxt;
   logic [WIDTH-1:0] second_nxt;

   always_comb begin
      first_nxt = async_i;
      second_nxt = first_r;
   end

   always_ff @(negedge clock_i) begin
      if (reset_i) begin
         // ones keep status idle, no false start after reset
         first_r <= '1;
         sync_o <= '1;
      end else begin
         first_r <= first_nxt;
         sync_o <= second_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== hw/status_decode_bus_controller.sv
// module: bus controller decoding status into commands
`timescale 1ns/1ps
`default_nettype none
module status_decode_bus_controller (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic status0_n_i,
   input wire logic status1_n_i,
   input wire logic space_select_i,
   input wire logic bus_timing_select_i,
   input wire logic latched_select_i,
   input wire logic command_delay_i,
   input wire logic dual_enable_i,
   input wire logic ready_n_i,
   output bus_ctrl_pkg::commands_t commands_o,
   output logic commands_oe_o,
   output logic transfer_direction_o,
   output logic transceiver_enable_o,
   output logic cascade_addr_enable_o
);
   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [7:0] pins_s;
   logic st0_n, st1_n, space_s, timing_s, select_s, delay_s, enable_s, ready_n_s;

   edge_sync #(.WIDTH(8)) sync_u (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .async_i({status0_n_i, status1_n_i, space_select_i, bus_timing_select_i,
                latched_select_i, command_delay_i, dual_enable_i, ready_n_i}),
      .sync_o(pins_s)
   );

   always_comb begin
      {st0_n, st1_n, space_s, timing_s, select_s, delay_s, enable_s, ready_n_s} = pins_s;
   end

   // ****************************************************************
   // state
   // ****************************************************************
   bus_ctrl_pkg::bus_state_t state_r, state_nxt;
   bus_ctrl_pkg::cycle_t cycle_r, cycle_nxt;
   logic phase_r, phase_nxt;
   logic selected_r, selected_nxt;
   logic issued_r, issued_nxt;
   bus_ctrl_pkg::commands_t cmd_r, cmd_nxt;
   logic oe_r, oe_nxt;
   logic dir_r, dir_nxt;
   logic xcvr_en_r, xcvr_en_nxt;
   logic cascade_r, cascade_nxt;
   logic is_write, is_xfer, granted, cmd_allow;
   bus_ctrl_pkg::commands_t decoded;

   always_comb begin
      state_nxt = state_r;
      cycle_nxt = cycle_r;
      phase_nxt = phase_r;
      selected_nxt = selected_r;
      issued_nxt = issued_r;
      is_write = (cycle_r == bus_ctrl_pkg::CYC_IO_WR) || (cycle_r == bus_ctrl_pkg::CYC_MEM_WR);
      is_xfer = (cycle_r != bus_ctrl_pkg::CYC_IDLE0) && (cycle_r != bus_ctrl_pkg::CYC_IDLE1)
                && (cycle_r != bus_ctrl_pkg::CYC_HALT);
      // strap picks grant (low active) or command enable (high active)
      granted = timing_s ? ~enable_s : 1'b1;
      cmd_allow = timing_s ? 1'b1 : enable_s;
      // one-hot command from the latched cycle type
      decoded = bus_ctrl_pkg::COMMANDS_RESET;
      decoded.irq_ack = (cycle_r == bus_ctrl_pkg::CYC_IRQ_ACK);
      decoded.io_read = (cycle_r == bus_ctrl_pkg::CYC_IO_RD);
      decoded.io_write = (cycle_r == bus_ctrl_pkg::CYC_IO_WR);
      decoded.mem_read = (cycle_r == bus_ctrl_pkg::CYC_MEM_RD);
      decoded.mem_write = (cycle_r == bus_ctrl_pkg::CYC_MEM_WR);
      cmd_nxt = cmd_r;
      oe_nxt = granted;
      dir_nxt = dir_r;
      xcvr_en_nxt = xcvr_en_r;
      cascade_nxt = cascade_r;
      unique case (state_r)
         bus_ctrl_pkg::ST_IDLE: begin
            phase_nxt = 1'b0;
            cmd_nxt = bus_ctrl_pkg::COMMANDS_RESET;
            xcvr_en_nxt = 1'b0;
            cascade_nxt = 1'b0;
            if (!xcvr_en_r) begin
               dir_nxt = 1'b1;
            end
            if (!st0_n || !st1_n) begin
               state_nxt = bus_ctrl_pkg::ST_STATUS;
               cycle_nxt = bus_ctrl_pkg::cycle_t'({space_s, st1_n, st0_n});
            end
         end
         bus_ctrl_pkg::ST_STATUS: begin
            phase_nxt = ~phase_r;
            if (phase_r == bus_ctrl_pkg::PHASE_LAST) begin
               selected_nxt = select_s;
               issued_nxt = 1'b0;
               state_nxt = bus_ctrl_pkg::ST_COMMAND;
               if (select_s && is_xfer) begin
                  dir_nxt = is_write;
                  cascade_nxt = (cycle_r == bus_ctrl_pkg::CYC_IRQ_ACK);
                  // fast timing enables transceiver at once for all
                  xcvr_en_nxt = granted && cmd_allow && !(timing_s && is_write);
               end
            end
         end
         bus_ctrl_pkg::ST_COMMAND: begin
            phase_nxt = ~phase_r;
            cascade_nxt = 1'b0;
            if (selected_r && is_xfer) begin
               xcvr_en_nxt = granted && cmd_allow;
               // system-bus timing holds commands off until second clock
               if (!issued_r && !delay_s && cmd_allow && granted
                   && (!timing_s || phase_r)) begin
                  cmd_nxt = decoded;
                  issued_nxt = 1'b1;
               end
               if (!cmd_allow || !granted) begin
                  cmd_nxt = bus_ctrl_pkg::COMMANDS_RESET;
               end
            end
            if (phase_r == bus_ctrl_pkg::PHASE_LAST && !ready_n_s) begin
               // end cycle, even if no command issued
               cmd_nxt = bus_ctrl_pkg::COMMANDS_RESET;
               xcvr_en_nxt = 1'b0;
               selected_nxt = 1'b0;
               state_nxt = bus_ctrl_pkg::ST_IDLE;
               if (!st0_n || !st1_n) begin
                  state_nxt = bus_ctrl_pkg::ST_STATUS;
                  phase_nxt = 1'b0;
                  cycle_nxt = bus_ctrl_pkg::cycle_t'({space_s, st1_n, st0_n});
               end
            end
            // ready high at end repeats command as wait state
         end
         default: begin
            state_nxt = bus_ctrl_pkg::ST_IDLE;
         end
      endcase
   end

   // all registers update on falling edge
   always_ff @(negedge clock_i) begin
      if (reset_i) begin
         state_r <= bus_ctrl_pkg::ST_IDLE;
         cycle_r <= bus_ctrl_pkg::CYC_IDLE1;
         phase_r <= 1'b0;
         selected_r <= 1'b0;
         issued_r <= 1'b0;
         cmd_r <= bus_ctrl_pkg::COMMANDS_RESET;
         oe_r <= 1'b0;
         dir_r <= 1'b1;
         xcvr_en_r <= 1'b0;
         cascade_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cycle_r <= cycle_nxt;
         phase_r <= phase_nxt;
         selected_r <= selected_nxt;
         issued_r <= issued_nxt;
         cmd_r <= cmd_nxt;
         oe_r <= oe_nxt;
         dir_r <= dir_nxt;
         xcvr_en_r <= xcvr_en_nxt;
         cascade_r <= cascade_nxt;
      end
   end

   always_comb begin
      commands_o = cmd_r;
      commands_oe_o = oe_r;
      transfer_direction_o = dir_r;
      transceiver_enable_o = xcvr_en_r;
      cascade_addr_enable_o = cascade_r;
   end
endmodule
`default_nettype wire

// ===== bench/status_master.sv
// model: bus master driving the status lines
`timescale 1ns/1ps
`default_nettype none
module status_master (
   input wire logic clock_i,
   input wire logic start_i,
   input wire logic [2:0] code_i,
   output logic status0_n_o,
   output logic status1_n_o,
   output logic space_select_o
);
   logic [1:0] hold_r = 2'h0;
   logic [2:0] drive_r = 3'h7;
   always_comb begin
      {space_select_o, status1_n_o, status0_n_o} = drive_r;
   end
   // status held two system clocks
   always @(posedge clock_i) begin
      if (start_i) begin
         drive_r <= code_i;
         hold_r <= 2'h2;
      end else if (hold_r != 2'h0) begin
         hold_r <= hold_r - 2'h1;
         if (hold_r == 2'h1) begin
            drive_r <= {~drive_r[2], 2'h3};
         end
      end
   end
endmodule
`default_nettype wire

// ===== bench/sdbc_checker_assertions.sv
// checker: port assertions for the bus controller
`timescale 1ns/1ps
`default_nettype none
module sdbc_checker (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic status0_n_i,
   input wire logic status1_n_i,
   input wire logic bus_timing_select_i,
   input wire logic command_delay_i,
   input wire logic dual_enable_i,
   input wire logic ready_n_i,
   input wire bus_ctrl_pkg::commands_t commands_o,
   input wire logic commands_oe_o,
   input wire logic transfer_direction_o,
   input wire logic transceiver_enable_o,
   input wire logic cascade_addr_enable_o
);
   default clocking
      @(negedge clock_i);
   endclocking
   default disable iff (reset_i);
   a_one_command: assert property ($onehot0(commands_o))
      else $error("two commands at once");
   a_dir_stable: assert property (transceiver_enable_o && $past(transceiver_enable_o)
      |-> $stable(transfer_direction_o)) else $error("direction moved while enabled");
   a_dir_command: assert property (|commands_o
      |-> transfer_direction_o == (commands_o.io_write || commands_o.mem_write))
      else $error("direction does not match command");
   a_float_enable: assert property ((bus_timing_select_i && dual_enable_i)[*4]
      |-> !commands_oe_o && !transceiver_enable_o) else $error("driven without grant");
   a_enable_off: assert property ((!bus_timing_select_i && !dual_enable_i)[*4]
      |-> commands_o == 5'h00 && !transceiver_enable_o) else $error("active while disabled");
   a_delay_hold: assert property (command_delay_i[*5] |-> !$rose(|commands_o))
      else $error("command rose under delay");
   a_wait_hold: assert property ((ready_n_i && !bus_timing_select_i && dual_enable_i)[*5]
      ##0 (|commands_o) |=> $stable(commands_o)) else $error("command moved in wait");
   a_idle_out: assert property ((status0_n_i && status1_n_i && !ready_n_i)[*8]
      |-> commands_o == 5'h00 && transfer_direction_o) else $error("idle outputs wrong");
   a_cascade_only: assert property (cascade_addr_enable_o
      |-> (commands_o & 5'h0f) == 5'h00) else $error("cascade outside acknowledge");
endmodule
bind status_decode_bus_controller sdbc_checker sdbc_checker_i (.clock_i(clock_i),
   .reset_i(reset_i), .status0_n_i(status0_n_i), .status1_n_i(status1_n_i),
   .bus_timing_select_i(bus_timing_select_i), .command_delay_i(command_delay_i),
   .dual_enable_i(dual_enable_i), .ready_n_i(ready_n_i), .commands_o(commands_o),
   .commands_oe_o(commands_oe_o), .transfer_direction_o(transfer_direction_o),
   .transceiver_enable_o(transceiver_enable_o), .cascade_addr_enable_o(cascade_addr_enable_o));
`default_nettype wire

// ===== bench/status_decode_bus_controller_tb.sv
// testbench: bus controller against a status master
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module status_decode_bus_controller_tb;
   logic clock_i = 1'b0, reset_i = 1'b1, start = 1'b0, bus_timing_select_i = 1'b0;
   logic latched_select_i = 1'b1, command_delay_i = 1'b0, dual_enable_i = 1'b1;
   logic ready_n_i = 1'b0, status0_n_i, status1_n_i, space_select_i;
   logic commands_oe_o, transfer_direction_o, transceiver_enable_o, cascade_addr_enable_o;
   logic [2:0] code = 3'h7;
   bus_ctrl_pkg::commands_t commands_o;
   int compares = 0, miscompares = 0;
   int cascade_pulses = 0, mark = 0;
   // code, command, direction
   logic [8:0] rows [8] = '{9'h020, 9'h050, 9'h089, 9'h0c1, 9'h101, 9'h144, 9'h183, 9'h1c1};
   initial begin
      forever #2.5 clock_i = ~clock_i;
   end
   // counts clocks with cascade enable high
   always @(posedge clock_i) begin
      if (cascade_addr_enable_o) begin
         cascade_pulses++;
      end
   end
   status_master status_master_i (.clock_i(clock_i), .start_i(start), .code_i(code),
      .status0_n_o(status0_n_i), .status1_n_o(status1_n_i), .space_select_o(space_select_i));
   status_decode_bus_controller status_decode_bus_controller_i (.clock_i(clock_i),
      .reset_i(reset_i), .status0_n_i(status0_n_i), .status1_n_i(status1_n_i),
      .space_select_i(space_select_i), .bus_timing_select_i(bus_timing_select_i),
      .latched_select_i(latched_select_i), .command_delay_i(command_delay_i),
      .dual_enable_i(dual_enable_i), .ready_n_i(ready_n_i), .commands_o(commands_o),
      .commands_oe_o(commands_oe_o), .transfer_direction_o(transfer_direction_o),
      .transceiver_enable_o(transceiver_enable_o), .cascade_addr_enable_o(cascade_addr_enable_o));
   task automatic summarize();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ****************************
   // bus cycle helpers
   // ****************************
   task automatic cycle(input logic [2:0] c, input logic dly, input logic rdy_n);
      @(posedge clock_i);
      code <= c;
      start <= 1'b1;
      command_delay_i <= dly;
      ready_n_i <= rdy_n;
      @(posedge clock_i);
      start <= 1'b0;
      for (int i = 0; i < 12 && commands_o === 5'h00; i++) @(posedge clock_i);
   endtask
   task automatic finish_cycle();
      @(posedge clock_i);
      ready_n_i <= 1'b0;
      command_delay_i <= 1'b0;
      for (int i = 0; i < 12 && commands_o !== 5'h00; i++) @(posedge clock_i);
      `CHK(commands_o, 5'h00)
      repeat (8) @(posedge clock_i);
      $display("test done at %0t", $time);
   endtask
   initial begin
      #20000;
      miscompares++;
      summarize();
   end
   initial begin
      repeat (6) @(posedge clock_i);
      reset_i <= 1'b0;
      `CHK({commands_o, commands_oe_o, transfer_direction_o}, 7'h01)
      `CHK({transceiver_enable_o, cascade_addr_enable_o}, 2'h0)
      $display("test done at %0t", $time);
      foreach (rows[r]) begin
         mark = cascade_pulses;
         cycle(rows[r][8:6], 1'b0, 1'b1);
         `CHK(commands_o, rows[r][5:1])
         `CHK(transfer_direction_o, rows[r][0])
         `CHK(cascade_pulses - mark, rows[r][5])
         `CHK(transceiver_enable_o, |rows[r][5:1])
         repeat (4) @(posedge clock_i);
         `CHK(commands_o, rows[r][5:1])
         finish_cycle();
      end
      latched_select_i <= 1'b0;
      cycle(3'h5, 1'b0, 1'b1);
      `CHK({commands_o, transceiver_enable_o}, 6'h00)
      finish_cycle();
      latched_select_i <= 1'b1;
      cycle(3'h6, 1'b1, 1'b1);
      `CHK(commands_o, 5'h00)
      command_delay_i <= 1'b0;
      for (int i = 0; i < 12 && commands_o === 5'h00; i++) @(posedge clock_i);
      `CHK(commands_o, 5'h01)
      finish_cycle();
      cycle(3'h5, 1'b1, 1'b0);
      command_delay_i <= 1'b0;
      for (int i = 0; i < 12 && commands_o === 5'h00; i++) @(posedge clock_i);
      `CHK(commands_o, 5'h00)
      finish_cycle();
      bus_timing_select_i <= 1'b1;
      cycle(3'h5, 1'b0, 1'b1);
      `CHK({commands_oe_o, transceiver_enable_o}, 2'h0)
      finish_cycle();
      dual_enable_i <= 1'b0;
      cycle(3'h5, 1'b0, 1'b1);
      `CHK({commands_o, commands_oe_o}, 6'h05)
      finish_cycle();
      bus_timing_select_i <= 1'b0;
      cycle(3'h5, 1'b0, 1'b1);
      `CHK(commands_o, 5'h00)
      finish_cycle();
      summarize();
   end
endmodule
`default_nettype wire
